// [logic/sync_consts.svh]
// Constants for the automatic serial busy and strobe synchroniser.
`ifndef SYNC_CONSTS_SVH
`define SYNC_CONSTS_SVH
`define CLK_PERIOD_NS     8
`define SCK_HALF_NS       32
`define SCK_HALF_CYC      (`SCK_HALF_NS / `CLK_PERIOD_NS)
`define CPU_DIV_CYC       1
`define GAP_HALVES        3'h5
`define GAP_CPU_OTHER     6'h0E
`define GAP_CPU_WAIT1     6'h12
`define GAP_CPU_MUL       6'h1A
`define GAP_CPU_DIV       6'h28
`define BUSY_RISE_AFTER   2'h2
`define BYTE_BITS         4'h8
`define FIFO_DEPTH        4
`define BYTE_W            8
`endif

// [logic/sync_pkg.sv]
// Types shared by the automatic serial synchroniser.
package sync_pkg;
    typedef enum logic [1:0] {
        CPU_OTHER,
        CPU_WAIT1,
        CPU_MUL,
        CPU_DIV
    } cpu_act_t;
    typedef struct packed {
        logic auto_xfer_on;
        logic clock_source_select;
        logic hold_polarity_select;
        logic hold_check_enable;
        logic byte_end_pulse_enable;
        logic xfer_active_flag;
        logic gap_ctrl_on;
    } ctrl_t;
    typedef struct packed {
        logic out;
        logic oe;
    } pin_drv_t;
    typedef enum {
        ST_IDLE,
        ST_READY,
        ST_SHIFT,
        ST_STROBE,
        ST_GAP,
        ST_WAIT_BUSY
    } xfer_state_t;
endpackage

// [logic/byte_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk,      // Clock.
    input  wire logic         srst,     // Synchronous reset.
    input  wire logic [W-1:0] in_data,  // Write data.
    input  wire logic         in_valid, // Write request.
    output logic              in_ready, // Space free.
    output logic [W-1:0]      out_data, // Head word.
    output logic              out_valid,// Word held.
    input  wire logic         out_ready // Head taken.
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          wr, rd;

    assign in_ready  = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    always_comb begin
        wp_nxt  = wr ? ((wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1) : wp_r;
        rp_nxt  = rd ? ((rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (wr) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule // byte_fifo
`default_nettype wire

// [logic/auto_serial_busy_strobe_sync.sv]
// Busy, strobe and interval control of the automatic serial master.
// Operation
// (R01) Sample busy on serial clock falling edges; code samples the stall check at the second rising edge after the byte.
// (R02) Busy during a byte never pauses it.
// (R03) Busy at second rise after byte stalls.
// (R04) Polarity bit: zero high, one low active.
// (R05) Busy wait only with internal serial clock.
// (R06) Interval control enabled disables busy control.
// (R07) Inactive sample starts byte next falling edge.
// (R08) Busy release seen within one serial clock.
// (R09) Slave holds busy inactive 1.5 clocks.
// (R10) Transfer flag clear forces serial output low.
// (R11) Busy needs auto enable and check enable.
// (R12) Strobe pulse after each finished byte.
// (R13) Strobe needs auto enable and strobe enable.
// (R14) Strobe disabled: pin acts as port.
// (R15) Interrupt flag set after strobe ends.
// (R16) Busy and strobe usable together.
// (R17) Busy active during byte sets error.
// (R18) Slave busy after eighth rise, drops quickly.
// (R19) Gap after each byte for buffer access.
// (R20) Internal gap: max 2.5 clocks, CPU count.
// (R21) External clock source keeps CPU-count gap; code ends the gap at once with the external clock.
`include "sync_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module auto_serial_busy_strobe_sync
    import sync_pkg::*;
#(
    parameter int SCK_HALF = `SCK_HALF_CYC,
    parameter int CPU_DIV  = `CPU_DIV_CYC
) (
    input  wire logic        CLOCK,        // 125 MHz clock.
    input  wire logic        SRST,         // Synchronous reset, high.
    input  wire ctrl_t       CTRL,         // Mode and enable bits.
    input  wire cpu_act_t    CPU_ACT,      // Current CPU activity.
    input  wire logic [7:0]  TX_DATA,      // Byte to send.
    input  wire logic        TX_VALID,     // Byte offered.
    output logic             TX_READY,     // FIFO has room.
    output logic [7:0]       RX_DATA,      // Byte received.
    output logic             RX_VALID,     // Received pulse.
    input  wire logic        SLAVE_HOLD_INPUT_PIN, // Busy from slave.
    input  wire logic        SERIAL_IN_PIN,// Serial data in.
    input  wire logic        SCK_IN,       // External serial clock.
    output logic             SCK_OUT,      // Internal serial clock.
    output logic             SCK_OE,       // Drives serial clock.
    output logic             SERIAL_OUT_PIN, // Serial data out.
    output logic             BYTE_END_PULSE_PIN, // Strobe or port out.
    output logic             BYTE_END_PULSE_OE,  // Strobe pin enable.
    input  wire pin_drv_t    PORT_DRV,     // Port value when strobe off.
    output logic             CHANNEL_ONE_IRQ_SET, // Flag set pulse.
    output logic             ERR_FLAG,     // Bit shift error.
    input  wire logic        ERR_CLR,      // Clears error flag.
    output logic             BYTE_DONE     // Byte finished pulse.
);
    logic [2:0]  pin_in;
    logic [2:0]  s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
    assign pin_in = {SCK_IN, SERIAL_IN_PIN, SLAVE_HOLD_INPUT_PIN};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_comb begin
                lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
            end
            always_ff @(posedge CLOCK) begin
                // The clock pin idles high, so no false edge follows reset.
                if (SRST) begin
                    s1_r[g]  <= (g == 2);
                    s2_r[g]  <= (g == 2);
                    s3_r[g]  <= (g == 2);
                    lvl_r[g] <= (g == 2);
                end else begin
                    s1_r[g]  <= pin_in[g];
                    s2_r[g]  <= s1_r[g];
                    s3_r[g]  <= s2_r[g];
                    lvl_r[g] <= lvl_nxt[g];
                end
            end
        end
    endgenerate

    logic        int_clk, run, busy_act, busy_en, stb_en;
    logic [15:0] div_r, div_nxt, cdiv_r, cdiv_nxt;
    logic        sck_r, sck_nxt, ext_d_r, cpu_en;
    logic        fall_ev, rise_ev;
    logic [5:0]  gap_tgt;

    assign int_clk  = CTRL.clock_source_select;
    assign run      = CTRL.auto_xfer_on && CTRL.xfer_active_flag;
    assign busy_act = lvl_r[0] ^ CTRL.hold_polarity_select;       // [R04]
    assign busy_en  = CTRL.auto_xfer_on && CTRL.hold_check_enable // [R11]
                      && int_clk && !CTRL.gap_ctrl_on;            // [R05] [R06]
    assign stb_en   = CTRL.auto_xfer_on && CTRL.byte_end_pulse_enable; // [R13]

    always_comb begin
        div_nxt  = div_r + 16'h0001;
        sck_nxt  = sck_r;
        if (!run || !int_clk) begin
            div_nxt = 16'h0000;
            sck_nxt = 1'b1;
        end else if (div_r == 16'(SCK_HALF - 1)) begin
            div_nxt = 16'h0000;
            sck_nxt = !sck_r;
        end
        cdiv_nxt = (cdiv_r == 16'(CPU_DIV - 1)) ? 16'h0000 : cdiv_r + 16'h0001;
    end
    assign cpu_en  = (cdiv_r == 16'(CPU_DIV - 1));
    assign fall_ev = int_clk ? (sck_r && !sck_nxt) : (ext_d_r && !lvl_r[2]);
    assign rise_ev = int_clk ? (!sck_r && sck_nxt) : (!ext_d_r && lvl_r[2]);

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            div_r   <= 16'h0000;
            cdiv_r  <= 16'h0000;
            sck_r   <= 1'b1;
            ext_d_r <= 1'b1;
        end else begin
            div_r   <= div_nxt;
            cdiv_r  <= cdiv_nxt;
            sck_r   <= sck_nxt;
            ext_d_r <= lvl_r[2];
        end
    end

    always_comb begin
        case (CPU_ACT)
            CPU_MUL:   gap_tgt = `GAP_CPU_MUL;
            sync_pkg::CPU_DIV: gap_tgt = `GAP_CPU_DIV;
            CPU_WAIT1: gap_tgt = `GAP_CPU_WAIT1;
            default:   gap_tgt = `GAP_CPU_OTHER;
        endcase
    end

    xfer_state_t state_r, state_nxt;
    logic [3:0]  bit_r, bit_nxt;
    logic [7:0]  sh_r, sh_nxt, rx_r, rx_nxt;
    logic        so_r, so_nxt, err_r, err_nxt, stb_r, stb_nxt;
    logic        irq_r, irq_nxt, rxv_r, rxv_nxt, hit_r, hit_nxt;
    logic [5:0]  cpu_r, cpu_nxt;
    logic [2:0]  half_r, half_nxt;
    logic [1:0]  rise_r, rise_nxt;
    logic        f_rdy, f_valid, gap_done;
    logic [7:0]  f_data;

    byte_fifo #(.W(`BYTE_W), .D(`FIFO_DEPTH)) u_fifo (
        .clk       (CLOCK),
        .srst      (SRST),
        .in_data   (TX_DATA),
        .in_valid  (TX_VALID),
        .in_ready  (TX_READY),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_rdy)
    );

    assign f_rdy    = (state_r == ST_READY) && fall_ev && run;
    // With an external clock the source itself keeps the CPU-count gap.
    assign gap_done = !int_clk                                    // [R21]
                      || (half_r >= `GAP_HALVES && cpu_r >= gap_tgt); // [R20]

    always_comb begin
        state_nxt = state_r;
        bit_nxt   = bit_r;
        sh_nxt    = sh_r;
        rx_nxt    = rx_r;
        so_nxt    = so_r;
        err_nxt   = err_r && !ERR_CLR;
        stb_nxt   = stb_r;
        irq_nxt   = 1'b0;
        rxv_nxt   = 1'b0;
        hit_nxt   = hit_r;
        cpu_nxt   = cpu_r;
        half_nxt  = half_r;
        rise_nxt  = rise_r;
        case (state_r)
            ST_IDLE: begin
                if (run) begin
                    state_nxt = ST_READY;
                end
            end
            ST_READY: begin
                if (f_rdy && f_valid) begin
                    state_nxt = ST_SHIFT;                 // [R07]
                    sh_nxt    = {f_data[6:0], 1'b0};
                    so_nxt    = f_data[7];
                    bit_nxt   = 4'h0;
                end
            end
            ST_SHIFT: begin
                if (fall_ev && bit_r != 4'h0) begin
                    so_nxt = sh_r[7];
                    sh_nxt = {sh_r[6:0], 1'b0};
                end
                if (fall_ev && busy_en && busy_act) begin
                    err_nxt = 1'b1;                       // [R17] [R02]
                end
                if (rise_ev) begin
                    rx_nxt  = {rx_r[6:0], lvl_r[1]};
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r == `BYTE_BITS - 4'h1) begin
                        rxv_nxt   = 1'b1;
                        hit_nxt   = 1'b0;
                        cpu_nxt   = 6'h00;
                        half_nxt  = 3'h0;
                        rise_nxt  = 2'h0;
                        stb_nxt   = stb_en;               // [R12] [R16]
                        irq_nxt   = !stb_en;
                        state_nxt = stb_en ? ST_STROBE : ST_GAP; // [R19]
                    end
                end
            end
            ST_STROBE: begin
                if (fall_ev) begin
                    stb_nxt   = 1'b0;
                    irq_nxt   = 1'b1;                     // [R15]
                    half_nxt  = 3'h1;
                    state_nxt = ST_GAP;
                end
            end
            ST_GAP: begin
                if (cpu_en && cpu_r != 6'h3F) begin
                    cpu_nxt = cpu_r + 6'h01;
                end
                if ((fall_ev || rise_ev) && half_r != 3'h7) begin
                    half_nxt = half_r + 3'h1;
                end
                if (rise_ev && rise_r != 2'h3) begin
                    rise_nxt = rise_r + 2'h1;
                    if (rise_r + 2'h1 == `BUSY_RISE_AFTER) begin
                        hit_nxt = busy_en && busy_act;    // [R03]
                    end
                end
                if (gap_done && (rise_r >= `BUSY_RISE_AFTER || !busy_en)) begin
                    state_nxt = hit_r ? ST_WAIT_BUSY : ST_READY;
                end
            end
            ST_WAIT_BUSY: begin
                // A release is caught at the next falling edge at most.
                if (fall_ev && (!busy_act || !busy_en)) begin
                    state_nxt = ST_READY;                 // [R01] [R08]
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!run) begin
            state_nxt = ST_IDLE;
            so_nxt    = 1'b0;                             // [R10]
            stb_nxt   = 1'b0;
        end
        if (ERR_CLR && err_nxt && !err_r) begin
            err_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_r <= ST_IDLE;
            bit_r   <= 4'h0;
            sh_r    <= 8'h00;
            rx_r    <= 8'h00;
            so_r    <= 1'b0;
            err_r   <= 1'b0;
            stb_r   <= 1'b0;
            irq_r   <= 1'b0;
            rxv_r   <= 1'b0;
            hit_r   <= 1'b0;
            cpu_r   <= 6'h00;
            half_r  <= 3'h0;
            rise_r  <= 2'h0;
        end else begin
            state_r <= state_nxt;
            bit_r   <= bit_nxt;
            sh_r    <= sh_nxt;
            rx_r    <= rx_nxt;
            so_r    <= so_nxt;
            err_r   <= err_nxt;
            stb_r   <= stb_nxt;
            irq_r   <= irq_nxt;
            rxv_r   <= rxv_nxt;
            hit_r   <= hit_nxt;
            cpu_r   <= cpu_nxt;
            half_r  <= half_nxt;
            rise_r  <= rise_nxt;
        end
    end

    // The pin clock only toggles inside a byte; the phase keeps running.
    assign SCK_OUT             = sck_r || (state_r != ST_SHIFT);
    assign SCK_OE              = int_clk && run;
    assign SERIAL_OUT_PIN      = so_r;
    assign BYTE_END_PULSE_PIN  = stb_en ? stb_r : PORT_DRV.out;   // [R14]
    assign BYTE_END_PULSE_OE   = stb_en ? 1'b1 : PORT_DRV.oe;
    assign CHANNEL_ONE_IRQ_SET = irq_r;
    assign ERR_FLAG            = err_r;
    assign RX_DATA             = rx_r;
    assign RX_VALID            = rxv_r;
    assign BYTE_DONE           = rxv_r;

    chk_so_low_idle: assert property (@(posedge CLOCK) disable iff (SRST)
        !$past(run) |-> !SERIAL_OUT_PIN) else $error("so not low"); // [R10]
    chk_wait_no_start: assert property (@(posedge CLOCK) disable iff (SRST)
        state_r == ST_WAIT_BUSY && busy_en && busy_act && fall_ev
        |=> state_r != ST_READY) else $error("busy ignored"); // [R03]
    chk_wait_release: assert property (@(posedge CLOCK) disable iff (SRST)
        state_r == ST_WAIT_BUSY && run && fall_ev && !busy_act
        |=> state_r == ST_READY) else $error("no release"); // [R07]
    chk_busy_gate: assert property (@(posedge CLOCK) disable iff (SRST)
        (!int_clk || CTRL.gap_ctrl_on || !CTRL.hold_check_enable)
        |-> !busy_en) else $error("busy gate"); // [R05] [R06] [R11]
    chk_err_set: assert property (@(posedge CLOCK) disable iff (SRST)
        state_r == ST_SHIFT && run && fall_ev && busy_en && busy_act
        |=> ERR_FLAG) else $error("err missing"); // [R17]
    chk_shift_continues: assert property (@(posedge CLOCK) disable iff (SRST)
        state_r == ST_SHIFT && run && !rise_ev
        |=> state_r == ST_SHIFT) else $error("byte paused"); // [R02]
    chk_irq_after_stb: assert property (@(posedge CLOCK) disable iff (SRST)
        irq_r && stb_en |-> $past(stb_r)) else $error("irq early"); // [R15]
    chk_strobe_pulse: assert property (@(posedge CLOCK) disable iff (SRST)
        $rose(rxv_r) && stb_en && $past(run) |-> stb_r)
        else $error("no strobe"); // [R12]
    chk_port_mode: assert property (@(posedge CLOCK) disable iff (SRST)
        !stb_en |-> BYTE_END_PULSE_PIN == PORT_DRV.out)
        else $error("port lost"); // [R14]
endmodule // auto_serial_busy_strobe_sync
`default_nettype wire

// [test/slave_model.sv]
// Behavioural slave that drives hold, answers data and may clock the link.
`timescale 1ns/100ps
`default_nettype none
module slave_model (
    input  wire logic       clk,     // Clock.
    input  wire logic       srst,    // Reset.
    input  wire logic       sck,     // Serial clock on the wire.
    input  wire logic       mosi,    // Data from master.
    input  wire logic       pol,     // One for active-low hold.
    input  wire logic [1:0] mode,    // 0 quiet, 1 stall, 2 mid-byte.
    input  wire logic [9:0] stall,   // Stall length in cycles.
    input  wire logic [7:0] tx_byte, // Byte answered.
    input  wire logic       ext_en,  // Run external clock.
    output logic            busy,    // Hold line.
    output logic            miso,    // Data to master.
    output logic            sck_ext, // External clock.
    output logic [7:0]      rx_byte, // Byte taken.
    output logic            rx_stb   // Byte taken pulse.
);
    logic       sck_q;
    logic       act;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    int         hold_cnt;
    assign busy = act ^ pol;
    assign miso = tx_byte[3'h7 - bit_cnt];
    always @(posedge clk) begin
        rx_stb <= 1'b0;
        sck_q  <= sck;
        if (srst) begin
            bit_cnt  <= 3'h0;
            act      <= 1'b0;
            hold_cnt <= 0;
        end else begin
            // Release is held until the next byte asserts hold again, well past 1.5 clocks.
            if (hold_cnt > 0)
                hold_cnt <= hold_cnt - 1;
            else
                act <= 1'b0;
            if (!sck_q && sck) begin
                sh      <= {sh[6:0], mosi};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    rx_byte <= {sh[6:0], mosi};
                    rx_stb  <= 1'b1;
                    if (mode == 2'h1) begin
                        act      <= 1'b1;
                        hold_cnt <= int'(stall);
                    end
                end
                if (mode == 2'h2 && bit_cnt == 3'h3) begin
                    act      <= 1'b1;
                    hold_cnt <= 20;
                end
            end
        end
    end
    // The external clock idles high and leaves a long pause between frames.
    initial begin
        sck_ext = 1'b1;
        forever begin
            @(posedge clk);
            if (ext_en) begin
                repeat (8) begin
                    repeat (8) @(posedge clk);
                    sck_ext <= 1'b0;
                    repeat (8) @(posedge clk);
                    sck_ext <= 1'b1;
                end
                repeat (60) @(posedge clk);
            end
        end
    end
endmodule // slave_model
`default_nettype wire

// [test/auto_serial_busy_strobe_sync_tb.sv]
// Self-checking bench for the automatic serial synchroniser.
`timescale 1ns/100ps
`default_nettype none
module auto_serial_busy_strobe_sync_tb;
    import sync_pkg::*;
    localparam int SCK_H = 4;
    localparam int CPU_D = 1;
    logic CLOCK, SRST, TX_VALID, ERR_CLR, pol, ext_en;
    logic TX_READY, RX_VALID, SCK_OUT, SCK_OE, SERIAL_OUT_PIN;
    logic BYTE_END_PULSE_PIN, BYTE_END_PULSE_OE, CHANNEL_ONE_IRQ_SET;
    logic ERR_FLAG, BYTE_DONE, busy, miso, sck_ext, m_stb, stb_q, stb_since;
    logic [7:0] TX_DATA, RX_DATA, s_tx, m_rx;
    logic [1:0] mode;
    logic [9:0] stall;
    ctrl_t      ctrl;
    cpu_act_t   CPU_ACT;
    pin_drv_t   PORT_DRV;
    logic [7:0] exp_q[$];
    int err_total, n_compared, done_cnt, iv, iv_last, stb_rise, base;
    integer seed;
    wire sck = SCK_OE ? SCK_OUT : sck_ext;
    auto_serial_busy_strobe_sync #(.SCK_HALF(SCK_H), .CPU_DIV(CPU_D)) dut_u (
        .CLOCK(CLOCK), .SRST(SRST), .CTRL(ctrl), .CPU_ACT(CPU_ACT),
        .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
        .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
        .SLAVE_HOLD_INPUT_PIN(busy), .SERIAL_IN_PIN(miso),
        .SCK_IN(sck_ext), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE),
        .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
        .BYTE_END_PULSE_PIN(BYTE_END_PULSE_PIN),
        .BYTE_END_PULSE_OE(BYTE_END_PULSE_OE), .PORT_DRV(PORT_DRV),
        .CHANNEL_ONE_IRQ_SET(CHANNEL_ONE_IRQ_SET), .ERR_FLAG(ERR_FLAG),
        .ERR_CLR(ERR_CLR), .BYTE_DONE(BYTE_DONE));
    slave_model slave_u (
        .clk(CLOCK), .srst(SRST), .sck(sck), .mosi(SERIAL_OUT_PIN),
        .pol(pol), .mode(mode), .stall(stall), .tx_byte(s_tx),
        .ext_en(ext_en), .busy(busy), .miso(miso), .sck_ext(sck_ext),
        .rx_byte(m_rx), .rx_stb(m_stb));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic int gap_min(input cpu_act_t a);
        int c;
        c = (a == CPU_DIV) ? 40 : (a == CPU_MUL) ? 26 : (a == CPU_WAIT1) ? 18 : 14;
        return (5 * SCK_H > c * CPU_D) ? 5 * SCK_H : c * CPU_D;
    endfunction
    // Entered just after a rising edge; valid stays up across the bytes.
    task automatic send(input int n);
        logic [7:0] b;
        logic ok;
        TX_VALID <= 1'b1;
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            TX_DATA <= b;
            ok = 1'b0;
            while (!ok) begin
                @(negedge CLOCK);
                ok = TX_READY;
                @(posedge CLOCK);
            end
            exp_q.push_back(b);
        end
        TX_VALID <= 1'b0;
    endtask
    task automatic wait_done(input int n);
        int k;
        k = 0;
        while (done_cnt < n && k < 5000) begin
            @(posedge CLOCK);
            k++;
        end
        check(k < 5000, 1'b1);
    endtask
    always @(negedge CLOCK) begin
        if (BYTE_DONE === 1'b1) begin
            done_cnt++;
            iv_last = iv;
            iv = 0;
        end else
            iv++;
        if (ctrl.byte_end_pulse_enable && BYTE_END_PULSE_PIN === 1'b1 && !stb_q)
            stb_rise++;
        if (ctrl.byte_end_pulse_enable && CHANNEL_ONE_IRQ_SET === 1'b1) begin
            check(stb_since, 1'b1);
            stb_since = 1'b0;
        end
        if (BYTE_END_PULSE_PIN === 1'b1)
            stb_since = 1'b1;
        stb_q = BYTE_END_PULSE_PIN;
        if (m_stb && ctrl.clock_source_select)
            check(m_rx, exp_q.size() ? exp_q.pop_front() : 8'h00);
        if (RX_VALID === 1'b1 && ctrl.clock_source_select)
            check(RX_DATA, s_tx);
    end
    initial begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
    initial begin
        seed = 32'hD3BC;
        {SRST, TX_VALID, ERR_CLR, pol, ext_en, stb_q, stb_since} = 7'h40;
        {err_total, n_compared, done_cnt, iv, iv_last, stb_rise} = '0;
        ctrl = '0;
        CPU_ACT = CPU_OTHER;
        PORT_DRV = '0;
        TX_DATA = 8'h00;
        mode = 2'h0;
        stall = 10'h0C8;
        s_tx = 8'($random(seed));
        repeat (6) @(posedge CLOCK);
        SRST <= 1'b0;
        ctrl.auto_xfer_on <= 1'b1;
        ctrl.clock_source_select <= 1'b1;
        ctrl.byte_end_pulse_enable <= 1'b1;
        @(posedge CLOCK);
        send(4);
        @(negedge CLOCK);
        check(TX_READY, 1'b0);
        check(SERIAL_OUT_PIN, 1'b0);
        @(posedge CLOCK);
        base = done_cnt;
        ctrl.xfer_active_flag <= 1'b1;
        wait_done(base + 4);
        for (int a = 0; a < 4; a++) begin
            CPU_ACT <= cpu_act_t'(a);
            send(2);
            wait_done(done_cnt + 2);
            check(iv_last >= 15 * SCK_H + gap_min(cpu_act_t'(a)), 1'b1);
        end
        check(stb_rise[15:0], 16'(done_cnt));
        ctrl.hold_check_enable <= 1'b1;
        mode <= 2'h1;
        for (int p = 0; p < 2; p++) begin
            ctrl.hold_polarity_select <= p[0];
            pol <= p[0];
            send(2);
            wait_done(done_cnt + 2);
            check(iv_last > 200, 1'b1);
            check(iv_last <= 330, 1'b1);
        end
        for (int k = 0; k < 2; k++) begin
            ctrl.gap_ctrl_on <= (k == 0);
            ctrl.hold_check_enable <= (k == 0);
            send(2);
            wait_done(done_cnt + 2);
            check(iv_last < 200, 1'b1);
        end
        ctrl.gap_ctrl_on <= 1'b0;
        ctrl.hold_check_enable <= 1'b1;
        mode <= 2'h2;
        repeat (400) @(posedge CLOCK);
        send(2);
        wait_done(done_cnt + 2);
        check(ERR_FLAG, 1'b1);
        check(iv_last < 150, 1'b1);
        ERR_CLR <= 1'b1;
        @(posedge CLOCK);
        ERR_CLR <= 1'b0;
        ctrl.hold_check_enable <= 1'b0;
        send(1);
        wait_done(done_cnt + 1);
        check(ERR_FLAG, 1'b0);
        ctrl.byte_end_pulse_enable <= 1'b0;
        repeat (4) begin
            PORT_DRV <= pin_drv_t'($random(seed));
            @(negedge CLOCK);
            check({BYTE_END_PULSE_PIN, BYTE_END_PULSE_OE}, PORT_DRV);
            @(posedge CLOCK);
        end
        ctrl.clock_source_select <= 1'b0;
        ctrl.hold_check_enable <= 1'b1;
        mode <= 2'h1;
        stall <= 10'h3E8;
        send(2);
        ext_en <= 1'b1;
        wait_done(done_cnt + 2);
        ext_en <= 1'b0;
        check(iv_last < 400, 1'b1);
        complete_run();
    end
endmodule // auto_serial_busy_strobe_sync_tb
`default_nettype wire
